/* rtl/fso_cfg.svh */
/*
 holds offsets, field positions, reset values and timing counts of the fan
 smoothing and overtemperature configuration block.
 assumes inclusion by bare name from the package and modules.
*/
// Contract
// R01: bit 0 of the smoothing register multiplies channel-1 smoothing time by four.
// R02: bit 1 of the smoothing register multiplies channel-2 smoothing time by four.
// R03: bit 2 of the smoothing register multiplies channel-3 smoothing time by four.
// R04: bit 3 keeps the overtemperature pin active while fans are in manual mode.
// R05: software never writes reserved bits 5:4 of the first or 7:1 of the second register.
// R06: in core-voltage-low mode on standby power, a low core voltage sets status bit 1.
// R07: the same condition raises the alert output only when alerts are enabled.
// R08: while core voltage is low in that mode, processor-hot monitoring is suspended.
// R09: when core voltage recovers, processor-hot monitoring resumes and fans run a spin-up first.
// R10: bit 7 lengthens every smoothing time by a further 39.2 percent.
// R11: an overtemperature event overrides every fan setting, even with fans disabled; the code does not override in manual mode with bit 3 clear.
// R12: bit 0 of the hysteresis register set to 1 removes overtemperature hysteresis.
// R13: once the lock is set, the hysteresis register ignores all writes.
// R14: the smoothing register resets to zero.
// R15: the lock bit is write-once and holds until power is cycled.
// R16: reserved bits always read as zero.
`ifndef FSO_CFG_SVH
`define FSO_CFG_SVH

`define FSO_ADDR_SMOOTH 8'h40
`define FSO_ADDR_HYST 8'h44
`define FSO_ADDR_CTRL 8'h48
`define FSO_ADDR_STATUS 8'h4C
`define FSO_ADDR_IRQ_EN 8'h50
`define FSO_ADDR_IRQ_CLR 8'h54
`define FSO_IDX_SMOOTH 8'h10
`define FSO_IDX_HYST 8'h11

`define FSO_SMOOTH_RST 8'h00
`define FSO_HYST_RST 8'h00
`define FSO_SMOOTH_MASK 8'hCF
`define FSO_HYST_MASK 8'h01

`define FSO_BIT_SLOW_R1 0
`define FSO_BIT_SLOW_LOC 1
`define FSO_BIT_SLOW_R2 2
`define FSO_BIT_OT_MANUAL 3
`define FSO_BIT_CVL_MODE 6
`define FSO_BIT_STRETCH 7
`define FSO_BIT_HYS_OFF 0
`define FSO_BIT_LOCK 0
`define FSO_BIT_ALERT_EN 1
`define FSO_BIT_ST_CVL 1
`define FSO_BIT_ST_OT 0

`define FSO_SLOW_FACTOR 4
`define FSO_STRETCH_NUM 1392
`define FSO_STRETCH_DEN 1000
`define FSO_SPINUP_NS 2000
`define FSO_CLK_NS 10

`endif

/* rtl/fso_pkg.sv */
/*
 holds the types of the fan smoothing configuration block.
 assumes fso_cfg.svh for numeric constants.
*/
`include "fso_cfg.svh"
package fso_pkg;
    typedef enum logic [1:0] {FSO_FAN_RUN, FSO_FAN_HOLD, FSO_FAN_SPIN} fso_fan_state_t;
    typedef logic [7:0] fso_byte_t;
endpackage

/* rtl/fso_regs_if.sv */
/*
 carries register write strobes and register values between the top and
 the hysteresis/lock sub-block.
 assumes a single clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface fso_regs_if;
    logic wr_hyst;
    logic wr_lock;
    logic [7:0] wdata;
    logic hyst_off;
    logic locked;
    modport top (output wr_hyst, output wr_lock, output wdata, input hyst_off, input locked);
    modport sub (input wr_hyst, input wr_lock, input wdata, output hyst_off, output locked);
endinterface
`default_nettype wire

/* rtl/fso_lock_regs.sv */
/*
 holds the lock bit and the lockable hysteresis register.
 assumes write strobes arrive as one-cycle pulses from the bus slave.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fso_cfg.svh"
module fso_lock_regs
    import fso_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    fso_regs_if.sub rif
);
    logic lock;
    logic hyst;
    // R15 write once lock
    wire next_lock = lock | (rif.wr_lock & rif.wdata[`FSO_BIT_LOCK]);
    // R13 lock blocks writes
    wire hyst_we = rif.wr_hyst & ~lock;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lock <= 1'b0;
            hyst <= 1'b0;
        end
        else
        begin
            lock <= next_lock;
            if (hyst_we)
                hyst <= rif.wdata[`FSO_BIT_HYS_OFF];
        end
    end
    assign rif.locked = lock;
    assign rif.hyst_off = hyst;

    a_lock_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
        lock |=> lock) else $error("lock bit cleared"); // R15
    a_hyst_frozen: assert property (@(posedge clock_i) disable iff (rst_i)
        lock |=> $stable(hyst)) else $error("hysteresis changed while locked"); // R13
endmodule // fso_lock_regs
`default_nettype wire

/* rtl/fso_fan_smoothing_overtemp_config.sv */
/*
 fan smoothing and overtemperature configuration registers with APB slave,
 core-voltage-low supervision, smoothing time scaling and overtemperature
 priority.
 assumes synchronous inputs and a 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fso_cfg.svh"
module fso_fan_smoothing_overtemp_config
    import fso_pkg::*;
#(
    parameter int TIME_W = 16
)
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [TIME_W-1:0] base_time_i,
    output logic [TIME_W+3:0] smooth_time_r1_o,
    output logic [TIME_W+3:0] smooth_time_loc_o,
    output logic [TIME_W+3:0] smooth_time_r2_o,
    input wire logic standby_power_i,
    input wire logic core_voltage_below_i,
    input wire logic processor_hot_i,
    output logic processor_hot_monitor_o,
    output logic alert_o,
    input wire logic fans_manual_i,
    input wire logic fans_disabled_i,
    input wire logic [7:0] fan_duty_i,
    input wire logic overtemp_i,
    output logic overtemp_pin_o,
    output logic overtemp_hysteresis_off_o,
    output logic [7:0] fan_duty_o,
    output logic fan_spinup_o,
    output logic irq_o
);
    localparam int SPIN_CYC = (`FSO_SPINUP_NS + `FSO_CLK_NS - 1) / `FSO_CLK_NS;

    fso_regs_if rif();
    fso_byte_t smooth;
    logic alert_en;
    logic [1:0] status;
    logic [1:0] irq_en;
    logic cvl_prev;
    fso_fan_state_t fan_st;
    logic [15:0] spin_cnt;
    logic [31:0] rdata;

    function automatic logic [TIME_W+3:0] scale_time(input logic slow, input logic stretch,
        input logic [TIME_W-1:0] t);
        logic [TIME_W+13:0] s;
        s = {14'h0000, t};
        if (slow)
            s = (TIME_W+14)'(s * `FSO_SLOW_FACTOR);
        if (stretch)
            s = (TIME_W+14)'(s * `FSO_STRETCH_NUM / `FSO_STRETCH_DEN);
        return s[TIME_W+3:0];
    endfunction

    // bus decode
    wire acc = psel_i & penable_i;
    wire wr = acc & pwrite_i;
    wire hit_smooth = paddr_i == `FSO_ADDR_SMOOTH;
    wire hit_hyst = paddr_i == `FSO_ADDR_HYST;
    wire hit_ctrl = paddr_i == `FSO_ADDR_CTRL;
    wire hit_stat = paddr_i == `FSO_ADDR_STATUS;
    wire hit_en = paddr_i == `FSO_ADDR_IRQ_EN;
    wire hit_clr = paddr_i == `FSO_ADDR_IRQ_CLR;
    wire mapped = hit_smooth | hit_hyst | hit_ctrl | hit_stat | hit_en | hit_clr;
    // R15 smoothing register frozen by lock
    wire wr_smooth = wr & hit_smooth & ~rif.locked;
    wire wr_ctrl = wr & hit_ctrl;

    assign rif.wr_hyst = wr & hit_hyst;
    assign rif.wr_lock = wr_ctrl;
    assign rif.wdata = pwdata_i[7:0];

    fso_lock_regs u_lock (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .rif(rif)
    );

    // core-voltage-low condition
    wire cvl_mode = smooth[`FSO_BIT_CVL_MODE];
    wire cvl_active = cvl_mode & standby_power_i & core_voltage_below_i;
    wire cvl_recover = cvl_prev & ~cvl_active;
    wire [1:0] events = {cvl_active, overtemp_i};
    wire [1:0] clr_bits = (wr & hit_clr) ? pwdata_i[1:0] : 2'h0;
    wire [1:0] next_status = (status & ~clr_bits) | events;

    // R14 reset to zero, R16 reserved bits masked
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            smooth <= `FSO_SMOOTH_RST;
        else if (wr_smooth)
            smooth <= pwdata_i[7:0] & `FSO_SMOOTH_MASK;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            alert_en <= 1'b0;
            irq_en <= 2'h0;
            cvl_prev <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                alert_en <= pwdata_i[`FSO_BIT_ALERT_EN];
            if (wr & hit_en)
                irq_en <= pwdata_i[1:0];
            cvl_prev <= cvl_active;
        end
    end

    // R06 status set wins over clear
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            status <= 2'h0;
        else
            status <= next_status;
    end

    // R09 spin-up after recovery
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fan_st <= FSO_FAN_RUN;
            spin_cnt <= 16'h0000;
        end
        else
        begin
            unique case (fan_st)
                FSO_FAN_RUN:
                    if (cvl_active)
                        fan_st <= FSO_FAN_HOLD;
                FSO_FAN_HOLD:
                    if (cvl_recover)
                    begin
                        fan_st <= FSO_FAN_SPIN;
                        spin_cnt <= 16'(SPIN_CYC - 1);
                    end
                FSO_FAN_SPIN:
                    if (cvl_active)
                        fan_st <= FSO_FAN_HOLD;
                    else if (spin_cnt == 16'h0000)
                        fan_st <= FSO_FAN_RUN;
                    else
                        spin_cnt <= spin_cnt - 16'h0001;
                default:
                    fan_st <= FSO_FAN_RUN;
            endcase
        end
    end

    // read mux, R16 reserved reads zero
    assign rdata = hit_smooth ? {24'h0000_00, smooth} :
        hit_hyst ? {31'h0000_0000, rif.hyst_off} :
        hit_ctrl ? {30'h0000_0000, alert_en, rif.locked} :
        hit_stat ? {30'h0000_0000, status} :
        hit_en ? {30'h0000_0000, irq_en} : 32'h0000_0000;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            prdata_o <= 32'h0000_0000;
        else if (psel_i & ~penable_i & ~pwrite_i)
            prdata_o <= rdata;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            smooth_time_r1_o <= '0;
            smooth_time_loc_o <= '0;
            smooth_time_r2_o <= '0;
            fan_duty_o <= 8'h00;
        end
        else
        begin
            // R01 R10 channel-1 scaling
            smooth_time_r1_o <= scale_time(smooth[`FSO_BIT_SLOW_R1], smooth[`FSO_BIT_STRETCH], base_time_i);
            // R02 channel-2 scaling
            smooth_time_loc_o <= scale_time(smooth[`FSO_BIT_SLOW_LOC], smooth[`FSO_BIT_STRETCH], base_time_i);
            // R03 channel-3 scaling
            smooth_time_r2_o <= scale_time(smooth[`FSO_BIT_SLOW_R2], smooth[`FSO_BIT_STRETCH], base_time_i);
            // R11 active overtemperature pin overrides fans
            if (overtemp_pin_o)
                fan_duty_o <= 8'hFF;
            else if (fans_disabled_i || fan_st == FSO_FAN_HOLD)
                fan_duty_o <= 8'h00;
            else if (fan_st == FSO_FAN_SPIN)
                fan_duty_o <= 8'hFF;
            else
                fan_duty_o <= fan_duty_i;
        end
    end

    assign pready_o = 1'b1;
    assign pslverr_o = acc & ~mapped;
    // R04 overtemp pin in manual mode
    assign overtemp_pin_o = overtemp_i & (~fans_manual_i | smooth[`FSO_BIT_OT_MANUAL]);
    // R12 hysteresis off
    assign overtemp_hysteresis_off_o = rif.hyst_off;
    // R08 R09 processor-hot monitor gating
    assign processor_hot_monitor_o = processor_hot_i & ~cvl_active;
    // R07 alert only when enabled
    assign alert_o = alert_en & status[`FSO_BIT_ST_CVL];
    assign fan_spinup_o = fan_st == FSO_FAN_SPIN;
    assign irq_o = |(status & irq_en);

    a_cvl_sets: assert property (@(posedge clock_i) disable iff (rst_i)
        cvl_active |=> status[`FSO_BIT_ST_CVL]) else $error("status not set"); // R06
    a_alert_gate: assert property (@(posedge clock_i) disable iff (rst_i)
        (cvl_active && alert_en && !wr_ctrl) |=> alert_o) else $error("alert not raised"); // R07
    a_processor_hot_monitor_off: assert property (@(posedge clock_i) disable iff (rst_i)
        cvl_active |-> !processor_hot_monitor_o) else $error("monitor not suspended"); // R08
    a_spin_follows: assert property (@(posedge clock_i) disable iff (rst_i)
        (fan_st == FSO_FAN_HOLD && cvl_recover) |=> fan_spinup_o [*2]) else $error("no spin-up"); // R09
    a_ot_priority: assert property (@(posedge clock_i) disable iff (rst_i)
        overtemp_pin_o |=> fan_duty_o == 8'hFF) else $error("overtemp not priority"); // R11
    a_reserved_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        smooth[5:4] == 2'b00) else $error("reserved bits set"); // R16
    a_slow_r1: assert property (@(posedge clock_i) disable iff (rst_i)
        (smooth[0] && !smooth[7] && $stable(smooth)) |=> smooth_time_r1_o == {2'b00, $past(base_time_i), 2'b00})
        else $error("slow factor wrong"); // R01
    a_ot_manual: assert property (@(posedge clock_i) disable iff (rst_i)
        (overtemp_i && fans_manual_i && !smooth[3]) |-> !overtemp_pin_o) else $error("pin in manual"); // R04
    c_cvl: cover property (@(posedge clock_i) cvl_recover);
    c_lock: cover property (@(posedge clock_i) rif.locked && rif.wr_hyst);
    c_irq: cover property (@(posedge clock_i) irq_o);
endmodule // fso_fan_smoothing_overtemp_config
`default_nettype wire

/* tb/fso_testbench.sv */
/*
 self-checking bench for the fan smoothing and overtemperature config block.
 assumes fso_cfg.svh constants and a single 100 MHz clock with async reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fso_cfg.svh"
module testbench;
    import fso_pkg::*;
    logic clock_i, rst_i, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, duty, duty_o;
    logic [31:0] pwdata, prdata, rdata;
    logic rerr, standby, below, phot, phm, alert, manual, disabled, ot, ot_pin, hys_off, spin, irq;
    logic [15:0] base;
    logic [19:0] t_r1, t_loc, t_r2;
    logic [7:0] v;
    int mismatches, n_tests, k;

    fso_fan_smoothing_overtemp_config #(.TIME_W(16)) uut (.clock_i(clock_i), .rst_i(rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .base_time_i(base),
        .smooth_time_r1_o(t_r1), .smooth_time_loc_o(t_loc), .smooth_time_r2_o(t_r2),
        .standby_power_i(standby), .core_voltage_below_i(below), .processor_hot_i(phot),
        .processor_hot_monitor_o(phm), .alert_o(alert), .fans_manual_i(manual),
        .fans_disabled_i(disabled), .fan_duty_i(duty), .overtemp_i(ot), .overtemp_pin_o(ot_pin),
        .overtemp_hysteresis_off_o(hys_off), .fan_duty_o(duty_o), .fan_spinup_o(spin), .irq_o(irq));

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50)
        begin
            mismatches++;
            $display("[FAIL] %0t bus wait ran out", $time);
            give_verdict();
        end
    endtask

    function automatic logic [31:0] exp_time(input logic [15:0] b, input logic slow, input logic str);
        longint t;
        t = slow ? b * 4 : b;
        if (str)
            t = t * 1392 / 1000;
        return 32'(t);
    endfunction

    task wait_spin(input logic lvl);
        k = 0;
        while (spin !== lvl && k < 300)
        begin
            @(posedge clock_i);
            k++;
        end
        check({31'h0, spin}, {31'h0, lvl}, "spin-up level");
        if (spin !== lvl)
            give_verdict();
    endtask

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, standby, below, phot, manual, disabled, ot} = '0;
        base = 16'h0000; duty = 8'h00; mismatches = 0; n_tests = 0; rst_i = 1'b1;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        void'($urandom(32'h845374b0));
        apb(1'b0, `FSO_ADDR_SMOOTH, 32'h0000_0000);
        check(rdata, 32'h0000_0000, "smoothing reset value");
        apb(1'b0, `FSO_ADDR_HYST, 32'h0000_0000);
        check(rdata, 32'h0000_0000, "hysteresis reset value");
        for (int i = 0; i < 10; i++)
        begin
            v = (i == 0) ? 8'hCF : (i == 1) ? 8'h00 : 8'($urandom) & 8'hCF;
            base <= (i == 0) ? 16'hFFFF : 16'($urandom);
            apb(1'b1, `FSO_ADDR_SMOOTH, {24'h0, v});
            apb(1'b0, `FSO_ADDR_SMOOTH, 32'h0000_0000);
            check(rdata, {24'h0, v}, "smoothing readback");
            repeat (3) @(posedge clock_i);
            check(32'(t_r1), exp_time(base, v[0], v[7]), "channel 1 time");
            check(32'(t_loc), exp_time(base, v[1], v[7]), "local time");
            check(32'(t_r2), exp_time(base, v[2], v[7]), "channel 3 time");
            check(32'(t_r2), exp_time(base, v[2], v[7]), "stretched time");
        end
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, `FSO_ADDR_SMOOTH, {28'h0, i[1], 3'b000});
            manual <= i[0]; disabled <= i[0]; ot <= i[2]; duty <= 8'($urandom);
            repeat (3) @(posedge clock_i);
            check({31'h0, ot_pin}, {31'h0, i[2] & (~i[0] | i[1])}, "overtemp pin");
            check({24'h0, duty_o}, (i[2] & (~i[0] | i[1])) ? 32'h0000_00FF : i[0] ? 32'h0000_0000 :
                {24'h0, duty}, "fan duty priority");
        end
        {manual, disabled, ot} <= 3'b000;
        apb(1'b1, `FSO_ADDR_SMOOTH, 32'h0000_0040);
        phot <= 1'b1; standby <= 1'b1; below <= 1'b1;
        repeat (3) @(posedge clock_i);
        check({31'h0, phm}, 32'h0000_0000, "hot monitor suspended");
        check({31'h0, alert}, 32'h0000_0000, "alert while disabled");
        check({24'h0, duty_o}, 32'h0000_0000, "fans held while low");
        apb(1'b0, `FSO_ADDR_STATUS, 32'h0000_0000);
        check(rdata & 32'h0000_0002, 32'h0000_0002, "low voltage status");
        apb(1'b1, `FSO_ADDR_CTRL, 32'h0000_0002);
        apb(1'b1, `FSO_ADDR_IRQ_EN, 32'h0000_0002);
        repeat (2) @(posedge clock_i);
        check({31'h0, alert}, 32'h0000_0001, "alert enabled");
        check({31'h0, irq}, 32'h0000_0001, "irq raised");
        apb(1'b1, `FSO_ADDR_IRQ_EN, 32'h0000_0000);
        repeat (2) @(posedge clock_i);
        check({31'h0, irq}, 32'h0000_0000, "irq masked");
        below <= 1'b0;
        wait_spin(1'b1);
        check({31'h0, phm}, 32'h0000_0001, "hot monitor resumed");
        @(posedge clock_i);
        check({24'h0, duty_o}, 32'h0000_00FF, "spin-up duty");
        wait_spin(1'b0);
        repeat (3) @(posedge clock_i);
        check({24'h0, duty_o}, {24'h0, duty}, "fans back to programmed");
        apb(1'b1, `FSO_ADDR_IRQ_CLR, 32'h0000_0002);
        apb(1'b0, `FSO_ADDR_STATUS, 32'h0000_0000);
        check(rdata & 32'h0000_0002, 32'h0000_0000, "status cleared");
        check({31'h0, alert}, 32'h0000_0000, "alert dropped");
        apb(1'b1, `FSO_ADDR_HYST, 32'h0000_0001);
        repeat (2) @(posedge clock_i);
        check({31'h0, hys_off}, 32'h0000_0001, "hysteresis off");
        apb(1'b1, `FSO_ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, `FSO_ADDR_HYST, 32'h0000_0000);
        apb(1'b0, `FSO_ADDR_HYST, 32'h0000_0000);
        check(rdata, 32'h0000_0001, "locked hysteresis");
        check({31'h0, hys_off}, 32'h0000_0001, "locked hysteresis out");
        apb(1'b1, `FSO_ADDR_CTRL, 32'h0000_0000);
        apb(1'b0, `FSO_ADDR_CTRL, 32'h0000_0000);
        check(rdata & 32'h0000_0001, 32'h0000_0001, "lock write-once");
        apb(1'b1, `FSO_ADDR_SMOOTH, 32'h0000_0001);
        apb(1'b0, `FSO_ADDR_SMOOTH, 32'h0000_0000);
        check(rdata, 32'h0000_0040, "locked smoothing");
        apb(1'b1, 8'h7C, 32'h0000_0001);
        check({31'h0, rerr}, 32'h0000_0001, "unmapped error");
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        apb(1'b0, `FSO_ADDR_CTRL, 32'h0000_0000);
        check(rdata & 32'h0000_0001, 32'h0000_0000, "lock cleared by power cycle");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
